// ---- verilog/cmf_pkg.sv ----
package cmf_pkg;

    // ----------------
    // geometry
    // ----------------
    localparam int CMF_MBOX_N   = 32;
    localparam int CMF_IDX_W    = 5;
    localparam int CMF_LEGACY_N = 16;
    localparam int CMF_GMASK_LO = 6;
    localparam int CMF_LAM3_LO  = 3;

    // ----------------
    // register map (byte addresses, 12-bit window)
    // ----------------
    localparam logic [1:0]  CMF_MBOX_PAGE  = 2'h0;
    localparam logic [6:0]  CMF_GLOB_PAGE  = 7'h20;
    localparam logic [2:0]  CMF_FLD_ID     = 3'h0;
    localparam logic [2:0]  CMF_FLD_CTRL   = 3'h1;
    localparam logic [2:0]  CMF_FLD_DLO    = 3'h2;
    localparam logic [2:0]  CMF_FLD_DHI    = 3'h3;
    localparam logic [2:0]  CMF_FLD_LAM    = 3'h4;
    localparam logic [2:0]  CMF_GLB_EN     = 3'h0;
    localparam logic [2:0]  CMF_GLB_DIR    = 3'h1;
    localparam logic [2:0]  CMF_GLB_TRS    = 3'h2;
    localparam logic [2:0]  CMF_GLB_TRR    = 3'h3;
    localparam logic [2:0]  CMF_GLB_MC     = 3'h4;
    localparam logic [2:0]  CMF_GLB_GMASK  = 3'h5;

    // ----------------
    // field positions
    // ----------------
    localparam int CMF_TPL_MSB    = 12;
    localparam int CMF_TPL_LSB    = 8;
    localparam int CMF_RTR_BIT    = 4;
    localparam int CMF_DLC_MSB    = 3;
    localparam int CMF_IDE_BIT    = 31;
    localparam int CMF_AME_BIT    = 30;
    localparam int CMF_MEXT_BIT   = 31;
    localparam int CMF_ID_MSB     = 28;
    localparam int CMF_DBO_BIT    = 10;
    localparam int CMF_CDR_BIT    = 8;
    localparam int CMF_MAILBOX_NUMBER_SELECT_MSB   = 4;
    localparam int CMF_INIT_BIT   = 12;
    localparam int CMF_LEGACY_BIT = 13;

    // ----------------
    // write masks, compare masks, reset values
    // ----------------
    localparam logic [31:0] CMF_CTRL_WMASK = 32'h0000_1F1F;
    localparam logic [31:0] CMF_LAM_WMASK  = 32'h9FFF_FFFF;
    localparam logic [31:0] CMF_MC_WMASK   = 32'h0000_351F;
    localparam logic [28:0] CMF_STD_CMP    = 29'h1FFC_0000;
    localparam logic [28:0] CMF_EXT_CMP    = 29'h1FFF_FFFF;
    localparam logic [31:0] CMF_MC_RST     = 32'h0000_1000;
    localparam logic [31:0] CMF_GMASK_RST  = 32'h0000_0000;
    localparam logic [31:0] CMF_WORD_RST   = 32'h0000_0000;

    typedef enum logic [0:0] {
        CMF_BUS_IDLE = 1'b0,
        CMF_BUS_WAIT = 1'b1
    } cmf_bus_state_t;

endpackage : cmf_pkg

// ---- verilog/cmf_mailbox_filter.sv ----
`timescale 1ns/1ps
// Functional notes
// RULE_01: control word writable only transmit or disabled
// RULE_02: five-bit priority, larger value sent first
// RULE_03: equal priority: higher mailbox index first
// RULE_04: priority ignored in legacy mode
// RULE_05: receive remote request: send, clear, capture reply
// RULE_06: transmit remote request: reply not captured here
// RULE_07: software keeps length code at most eight
// RULE_08: software zeroes control words during initialization
// RULE_09: eight bytes, byte zero first on bus
// RULE_10: byte order set: byte zero low LSB
// RULE_11: byte order clear: byte zero low MSB
// RULE_12: data writes gated by direction, request, change-data
// RULE_13: same data gating for auto-answer mailboxes
// RULE_14: bytes beyond received length are indeterminate
// RULE_15: compare identifier except masked-out bits
// RULE_16: legacy: global group first, highest index wins
// RULE_17: legacy: mask three for 5-3, zero for 2-0
// RULE_18: legacy masks writable only in initialization mode
// RULE_19: enhanced: own mask each, highest match stores
// RULE_20: reset clears the global mask
// RULE_21: reset leaves local masks untouched
// RULE_22: mask one is don't-care, zero exact
// RULE_23: extension select accepts both formats
// RULE_24: mask enable clear means exact match
// RULE_25: refused writes leave contents unchanged
module cmf_mailbox_filter
    import cmf_pkg::*;
(
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 nrst,
    // ahb-lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    // transmit side of the protocol engine
    output logic                      tx_valid,
    output logic [CMF_IDX_W-1:0]      tx_mbox,
    output logic [31:0]               tx_id,
    output logic                      tx_rtr,
    output logic [3:0]                tx_dlc,
    output logic [63:0]               tx_data,
    input  wire logic                 tx_done,
    input  wire logic [CMF_IDX_W-1:0] tx_done_mbox,
    // receive side of the protocol engine
    input  wire logic                 rx_valid,
    input  wire logic [28:0]          rx_id,
    input  wire logic                 rx_ide,
    input  wire logic [3:0]           rx_dlc,
    input  wire logic [63:0]          rx_data,
    output logic                      rx_hit,
    output logic [CMF_IDX_W-1:0]      rx_hit_mbox
);

    // ----------------
    // storage
    // ----------------
    logic [31:0] mb_id   [CMF_MBOX_N];
    logic [31:0] mb_ctrl [CMF_MBOX_N];
    logic [31:0] mb_dlo  [CMF_MBOX_N];
    logic [31:0] mb_dhi  [CMF_MBOX_N];
    logic [31:0] mb_lam  [CMF_MBOX_N];
    logic [31:0] en_reg;
    logic [31:0] dir_reg;
    logic [31:0] trs_reg;
    logic [31:0] mc_reg;
    logic [31:0] gmask;

    function automatic logic [31:0] cmf_bswap(input logic [31:0] w);
        cmf_bswap = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction : cmf_bswap

    wire                 legacy  = mc_reg[CMF_LEGACY_BIT];
    wire                 init_md = mc_reg[CMF_INIT_BIT];
    wire                 data_byte_order     = mc_reg[CMF_DBO_BIT];
    wire                 change_data_request     = mc_reg[CMF_CDR_BIT];
    wire [CMF_IDX_W-1:0] mailbox_number_select    = mc_reg[CMF_MAILBOX_NUMBER_SELECT_MSB:0];

    // ----------------
    // bus front end: one wait state per transfer
    // ----------------
    // the wait state lets a write land before any following read
    // samples the register file, at a cost of one cycle per access
    cmf_bus_state_t state;
    logic [11:0]    a_addr;
    logic           a_write;

    wire take  = hsel & hready & htrans[1] & (state == CMF_BUS_IDLE);
    wire wr_go = (state == CMF_BUS_WAIT) & a_write;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state     <= CMF_BUS_IDLE;
            a_addr    <= 12'h000;
            a_write   <= 1'b0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hresp <= 1'b0;
            unique case (state)
                CMF_BUS_IDLE: begin
                    if (take) begin
                        state     <= CMF_BUS_WAIT;
                        a_addr    <= haddr[11:0];
                        a_write   <= hwrite;
                        hreadyout <= 1'b0;
                    end
                end
                CMF_BUS_WAIT: begin
                    state     <= CMF_BUS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    // ----------------
    // address decode and write permission
    // ----------------
    wire                 in_mbox = a_addr[11:10] == CMF_MBOX_PAGE;
    wire                 in_glob = a_addr[11:5] == CMF_GLOB_PAGE;
    wire [CMF_IDX_W-1:0] w_idx   = a_addr[9:5];
    wire [2:0]           w_fld   = a_addr[4:2];
    wire                 mb_wr   = wr_go & in_mbox;
    wire                 gl_wr   = wr_go & in_glob;

    wire ctrl_ok = ~dir_reg[w_idx] | ~en_reg[w_idx];                                  // RULE_01
    wire data_ok = ctrl_ok & (~trs_reg[w_idx] | (change_data_request & (mailbox_number_select == w_idx)));              // RULE_12 RULE_13
    wire id_ok   = ~en_reg[w_idx];
    wire mask_ok = ~legacy | init_md; // RULE_18

    wire wr_id   = mb_wr & (w_fld == CMF_FLD_ID) & id_ok;                             // RULE_25
    wire wr_ctrl = mb_wr & (w_fld == CMF_FLD_CTRL) & ctrl_ok;                         // RULE_25
    wire wr_dlo  = mb_wr & (w_fld == CMF_FLD_DLO) & data_ok;                          // RULE_25
    wire wr_dhi  = mb_wr & (w_fld == CMF_FLD_DHI) & data_ok;                          // RULE_25
    wire wr_lam  = mb_wr & (w_fld == CMF_FLD_LAM) & mask_ok;
    wire wr_en   = gl_wr & (w_fld == CMF_GLB_EN);
    wire wr_dir  = gl_wr & (w_fld == CMF_GLB_DIR);
    wire wr_trs  = gl_wr & (w_fld == CMF_GLB_TRS);
    wire wr_trr  = gl_wr & (w_fld == CMF_GLB_TRR);
    wire wr_mc   = gl_wr & (w_fld == CMF_GLB_MC);
    wire wr_gm   = gl_wr & (w_fld == CMF_GLB_GMASK) & mask_ok;                        // RULE_18

    // ----------------
    // read mux
    // ----------------
    wire [31:0] rd_mbox = (w_fld == CMF_FLD_ID)   ? mb_id[w_idx]   :
                          (w_fld == CMF_FLD_CTRL) ? mb_ctrl[w_idx] :
                          (w_fld == CMF_FLD_DLO)  ? mb_dlo[w_idx]  :
                          (w_fld == CMF_FLD_DHI)  ? mb_dhi[w_idx]  :
                          (w_fld == CMF_FLD_LAM)  ? mb_lam[w_idx]  : CMF_WORD_RST;
    wire [31:0] rd_glob = (w_fld == CMF_GLB_EN)    ? en_reg  :
                          (w_fld == CMF_GLB_DIR)   ? dir_reg :
                          (w_fld == CMF_GLB_TRS)   ? trs_reg :
                          (w_fld == CMF_GLB_MC)    ? mc_reg  :
                          (w_fld == CMF_GLB_GMASK) ? gmask   : CMF_WORD_RST;
    wire [31:0] rd_word = in_mbox ? rd_mbox : (in_glob ? rd_glob : CMF_WORD_RST);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hrdata <= CMF_WORD_RST;
        end else if ((state == CMF_BUS_WAIT) && !a_write) begin
            hrdata <= rd_word;
        end
    end

    // ----------------
    // acceptance filter, one slice per mailbox
    // ----------------
    logic [CMF_MBOX_N-1:0] rx_match;
    logic [CMF_MBOX_N-1:0] tx_elig;
    logic [CMF_MBOX_N-1:0] ide_keep;
    logic [4:0]            prio [CMF_MBOX_N];

    wire [28:0] cmp_bits = rx_ide ? CMF_EXT_CMP : CMF_STD_CMP;                        // RULE_23

    for (genvar n = 0; n < CMF_MBOX_N; n++) begin : g_mb
        wire        in_legacy = n < CMF_LEGACY_N;
        wire [31:0] lg_mask   = (n >= CMF_GMASK_LO) ? gmask :                         // RULE_16
                                (n >= CMF_LAM3_LO)  ? mb_lam[CMF_LAM3_LO] : mb_lam[0]; // RULE_17
        wire [31:0] sel_mask  = legacy ? lg_mask : mb_lam[n];                         // RULE_19
        wire [31:0] eff_mask  = mb_id[n][CMF_AME_BIT] ? sel_mask : CMF_WORD_RST;      // RULE_24
        wire        ide_ok    = eff_mask[CMF_MEXT_BIT] | (mb_id[n][CMF_IDE_BIT] == rx_ide);
        wire [28:0] diff      = (rx_id ^ mb_id[n][CMF_ID_MSB:0]) & cmp_bits;
        wire        idb_ok    = (diff & ~eff_mask[28:0]) == 29'h0000_0000;            // RULE_15 RULE_22
        wire        live      = en_reg[n] & (~legacy | in_legacy);
        wire        skip_cdr  = change_data_request & (mailbox_number_select == CMF_IDX_W'(n));

        // only receive mailboxes capture, so a transmit remote
        // request never has its answer land in its own mailbox
        assign rx_match[n] = live & dir_reg[n] & ide_ok & idb_ok;                     // RULE_06
        assign ide_keep[n] = ~eff_mask[CMF_MEXT_BIT];
        assign tx_elig[n]  = live & trs_reg[n] & ~skip_cdr &
                             (~dir_reg[n] | mb_ctrl[n][CMF_RTR_BIT]);                 // RULE_05
        assign prio[n]     = legacy ? 5'h00 : mb_ctrl[n][CMF_TPL_MSB:CMF_TPL_LSB];    // RULE_02 RULE_04
    end

    // ----------------
    // arbitration: ascending scan, ties go to the later index
    // ----------------
    logic                 best_found;
    logic [CMF_IDX_W-1:0] best_idx;
    logic [4:0]           best_prio;
    logic                 hit_found;
    logic [CMF_IDX_W-1:0] hit_idx;

    always_comb begin
        best_found = 1'b0;
        best_idx   = '0;
        best_prio  = 5'h00;
        for (int i = 0; i < CMF_MBOX_N; i++) begin
            if (tx_elig[i] && (!best_found || prio[i] >= best_prio)) begin            // RULE_02 RULE_03
                best_found = 1'b1;
                best_idx   = CMF_IDX_W'(i);
                best_prio  = prio[i];
            end
        end
    end

    always_comb begin
        hit_found = 1'b0;
        hit_idx   = '0;
        for (int i = 0; i < CMF_MBOX_N; i++) begin
            if (rx_match[i]) begin // RULE_16 RULE_19
                hit_found = 1'b1;
                hit_idx   = CMF_IDX_W'(i);
            end
        end
    end

    wire rx_store = rx_valid & hit_found;

    // byte k of the stream sits at bits 8k+7:8k
    wire [31:0] rx_lo = data_byte_order ? rx_data[31:0]  : cmf_bswap(rx_data[31:0]);              // RULE_10 RULE_11
    wire [31:0] rx_hi = data_byte_order ? rx_data[63:32] : cmf_bswap(rx_data[63:32]);             // RULE_10 RULE_11
    wire [31:0] tx_lo = data_byte_order ? mb_dlo[best_idx] : cmf_bswap(mb_dlo[best_idx]);         // RULE_09
    wire [31:0] tx_hi = data_byte_order ? mb_dhi[best_idx] : cmf_bswap(mb_dhi[best_idx]);         // RULE_09

    wire [31:0] rx_new_id = {ide_keep[hit_idx] ? mb_id[hit_idx][CMF_IDE_BIT] : rx_ide,
                             mb_id[hit_idx][30:29], rx_id};
    wire [31:0] rx_new_ctrl = {mb_ctrl[hit_idx][31:CMF_DLC_MSB+1], rx_dlc};

    // ----------------
    // global registers
    // ----------------
    wire [31:0] done_clr = tx_done ? (32'h0000_0001 << tx_done_mbox) : CMF_WORD_RST;  // RULE_05
    wire [31:0] trr_clr  = wr_trr ? hwdata : CMF_WORD_RST;
    wire [31:0] trs_set  = wr_trs ? hwdata : CMF_WORD_RST;
    wire [31:0] next_trs = (trs_reg & ~(done_clr | trr_clr)) | trs_set;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            en_reg  <= CMF_WORD_RST;
            dir_reg <= CMF_WORD_RST;
            trs_reg <= CMF_WORD_RST;
            mc_reg  <= CMF_MC_RST;
            gmask   <= CMF_GMASK_RST; // RULE_20
        end else begin
            trs_reg <= next_trs;
            if (wr_en) begin
                en_reg <= hwdata;
            end
            if (wr_dir) begin
                dir_reg <= hwdata;
            end
            if (wr_mc) begin
                mc_reg <= hwdata & CMF_MC_WMASK;
            end
            if (wr_gm) begin
                gmask <= hwdata & CMF_LAM_WMASK;
            end
        end
    end

    // ----------------
    // identifier and control words
    // ----------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < CMF_MBOX_N; i++) begin
                mb_id[i]   <= CMF_WORD_RST;
                mb_ctrl[i] <= CMF_WORD_RST;
            end
        end else begin
            if (wr_id) begin
                mb_id[w_idx] <= hwdata;
            end
            if (wr_ctrl) begin
                mb_ctrl[w_idx] <= hwdata & CMF_CTRL_WMASK;                            // RULE_01
            end
            if (rx_store) begin
                mb_id[hit_idx]   <= rx_new_id;                                        // RULE_23
                mb_ctrl[hit_idx] <= rx_new_ctrl;
            end
        end
    end

    // ----------------
    // data words and local masks
    // ----------------
    // no reset here: masks survive a module reset, and data has
    // no defined content until written or received
    always_ff @(posedge sys_clk) begin
        if (wr_dlo) begin
            mb_dlo[w_idx] <= hwdata; // RULE_12
        end
        if (wr_dhi) begin
            mb_dhi[w_idx] <= hwdata; // RULE_12
        end
        if (wr_lam) begin
            mb_lam[w_idx] <= hwdata & CMF_LAM_WMASK; // RULE_21
        end
        if (rx_store) begin
            // all eight bytes are rewritten whatever the length
            mb_dlo[hit_idx] <= rx_lo; // RULE_14
            mb_dhi[hit_idx] <= rx_hi; // RULE_14
        end
    end

    // ----------------
    // engine-facing outputs
    // ----------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_valid    <= 1'b0;
            tx_mbox     <= '0;
            tx_id       <= CMF_WORD_RST;
            tx_rtr      <= 1'b0;
            tx_dlc      <= 4'h0;
            tx_data     <= 64'h0000_0000_0000_0000;
            rx_hit      <= 1'b0;
            rx_hit_mbox <= '0;
        end else begin
            tx_valid <= best_found;
            tx_mbox  <= best_idx;
            tx_id    <= mb_id[best_idx];
            tx_rtr   <= mb_ctrl[best_idx][CMF_RTR_BIT];
            tx_dlc   <= mb_ctrl[best_idx][CMF_DLC_MSB:0];
            tx_data  <= {tx_hi, tx_lo}; // RULE_09
            rx_hit   <= rx_store;
            if (rx_store) begin
                rx_hit_mbox <= hit_idx;
            end
        end
    end

endmodule : cmf_mailbox_filter

// ---- bench/cmf_mailbox_filter_sva.sv ----
`timescale 1ns/1ps
module cmf_mailbox_filter_sva
    import cmf_pkg::*;
(
    // clock and reset
    input wire logic                 sys_clk,
    input wire logic                 nrst,
    // bus
    input wire logic                 hsel,
    input wire logic [1:0]           htrans,
    input wire logic                 hready,
    input wire logic                 hreadyout,
    input wire logic                 hresp,
    input wire logic [31:0]          hrdata,
    // engine
    input wire logic                 tx_valid,
    input wire logic [CMF_IDX_W-1:0] tx_mbox,
    input wire logic                 tx_done,
    input wire logic [CMF_IDX_W-1:0] tx_done_mbox,
    input wire logic                 rx_valid,
    input wire logic                 rx_hit,
    input wire logic [CMF_IDX_W-1:0] rx_hit_mbox
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    hit_cause_a: assert property (rx_hit |-> $past(rx_valid))
        else $error("hit without frame");
    hit_quiet_a: assert property ((!rx_valid) [*2] |-> !rx_hit)
        else $error("hit while bus quiet");
    hit_index_a: assert property ($changed(rx_hit_mbox) |-> rx_hit)
        else $error("hit index moved without store");
    resp_okay_a: assert property (!hresp)
        else $error("error response");
    wait_state_a: assert property (hsel && hready && htrans[1] && hreadyout |=> !hreadyout ##1 hreadyout)
        else $error("wait state count");
    ready_once_a: assert property (!hreadyout |=> hreadyout)
        else $error("ready held low");
    rdata_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data moved");
    tx_clear_a: assert property (tx_done && tx_valid && tx_done_mbox == tx_mbox && !hsel && !$past(hsel)
        |-> ##2 (!tx_valid || tx_mbox != $past(tx_mbox, 2)))
        else $error("sent mailbox still offered");
endmodule : cmf_mailbox_filter_sva

bind cmf_mailbox_filter cmf_mailbox_filter_sva u_sva (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel),
    .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .tx_valid(tx_valid), .tx_mbox(tx_mbox), .tx_done(tx_done), .tx_done_mbox(tx_done_mbox),
    .rx_valid(rx_valid), .rx_hit(rx_hit), .rx_hit_mbox(rx_hit_mbox));

// ---- bench/cmf_engine_model.sv ----
`timescale 1ns/1ps
module cmf_engine_model
    import cmf_pkg::*;
(
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 nrst,
    // controller side
    input  wire logic                 tx_valid,
    input  wire logic [CMF_IDX_W-1:0] tx_mbox,
    output logic                      tx_done,
    output logic [CMF_IDX_W-1:0]      tx_done_mbox,
    // bench control
    input  wire logic                 hold,
    input  wire logic [1:0]           delay
);
    logic [CMF_IDX_W-1:0] pick;
    initial begin
        tx_done = 1'b0;
        tx_done_mbox = '0;
        forever begin
            @(posedge sys_clk);
            if (nrst && tx_valid === 1'b1 && !hold) begin
                // mailbox latched when arbitration is won
                pick = tx_mbox;
                repeat (delay + 1) @(posedge sys_clk);
                tx_done <= 1'b1;
                tx_done_mbox <= pick;
                @(posedge sys_clk);
                tx_done <= 1'b0;
                tx_done_mbox <= ~pick;
                repeat (2) @(posedge sys_clk);
            end
        end
    end
endmodule : cmf_engine_model

// ---- bench/tb_cmf_mailbox_filter.sv ----
`timescale 1ns/1ps
module tb_cmf_mailbox_filter
    import cmf_pkg::*;
;
    logic        sys_clk, nrst, hsel, hwrite, hready, hreadyout, hresp, data_byte_order;
    logic        tx_valid, tx_rtr, tx_done, rx_valid, rx_ide, rx_hit, hold;
    logic [1:0]  htrans;
    logic [3:0]  tx_dlc, rx_dlc;
    logic [4:0]  tx_mbox, tx_done_mbox, rx_hit_mbox, sent[$];
    logic [28:0] rx_id, id, m, x;
    logic [31:0] haddr, hwdata, hrdata, tx_id, r, lo, hi;
    logic [63:0] tx_data, rx_data, d;
    int          num_errors, samples_checked, seed, k;
    assign hready = hreadyout;

    cmf_mailbox_filter DUT (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .tx_valid(tx_valid), .tx_mbox(tx_mbox), .tx_id(tx_id),
        .tx_rtr(tx_rtr), .tx_dlc(tx_dlc), .tx_data(tx_data), .tx_done(tx_done), .tx_done_mbox(tx_done_mbox),
        .rx_valid(rx_valid), .rx_id(rx_id), .rx_ide(rx_ide), .rx_dlc(rx_dlc), .rx_data(rx_data),
        .rx_hit(rx_hit), .rx_hit_mbox(rx_hit_mbox));
    cmf_engine_model u_eng (.sys_clk(sys_clk), .nrst(nrst), .tx_valid(tx_valid), .tx_mbox(tx_mbox),
        .tx_done(tx_done), .tx_done_mbox(tx_done_mbox), .hold(hold), .delay(k[1:0]));

    // ----------------
    // helpers
    // ----------------
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        #100000;
        num_errors++;
        stop_test();
    end
    always @(posedge sys_clk) if (tx_done === 1'b1) sent.push_back(tx_done_mbox);
    function automatic logic [31:0] ma(input int n, input logic [2:0] f);
        return {22'h0, n[4:0], f, 2'b00};
    endfunction : ma
    function automatic logic [31:0] ga(input logic [2:0] g);
        return {20'h0, CMF_GLOB_PAGE, g, 2'b00};
    endfunction : ga
    function automatic logic [31:0] sw(input logic [31:0] v);
        return {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction : sw
    // mailbox 7 masked, 5 and 8 exact; tried in the order 7, then 5, then 8
    function automatic logic [5:0] hit_of(input logic [28:0] f);
        if (((f ^ id) & ~m) == 29'h0) return 6'h27;
        if (f == (id ^ 29'h1)) return 6'h25;
        if (f == ~id) return 6'h28;
        return 6'h00;
    endfunction : hit_of
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rv);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
        rv = hrdata;
    endtask : ahb
    task automatic wr(input logic [31:0] a, input logic [31:0] wd);
        logic [31:0] nul;
        ahb(1'b1, a, wd, nul);
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] rv);
        ahb(1'b0, a, 32'h0, rv);
    endtask : rd
    task automatic frame(input logic [28:0] f, input logic [5:0] ex);
        d = {$random(seed), $random(seed)};
        rx_valid <= 1'b1;
        rx_id <= f;
        rx_ide <= 1'b1;
        rx_dlc <= 4'h8;
        rx_data <= d;
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        rx_id <= ~f;
        rx_data <= ~d;
        #1;
        chk(rx_hit, ex[5]);
        if (ex[5]) chk(rx_hit_mbox, ex[4:0]);
        @(posedge sys_clk);
        if (ex[5]) rd(ma(ex[4:0], CMF_FLD_DLO), r);
        if (ex[5]) chk(r, data_byte_order ? d[31:0] : sw(d[31:0]));
    endtask : frame
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test

    // ----------------
    // tests
    // ----------------
    initial begin
        seed = 96772;
        nrst = 1'b0;
        hold = 1'b1;
        data_byte_order = 1'b0;
        {hsel, hwrite, rx_valid, rx_ide, htrans} = 6'h0;
        {haddr, hwdata, rx_id, rx_dlc, rx_data} = '0;
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(ga(CMF_GLB_MC), r);
        chk(r, CMF_MC_RST);
        rd(ga(CMF_GLB_GMASK), r);
        chk(r, CMF_GMASK_RST);
        rd(32'h0000_0418, r);
        chk(r, 64'h0);
        for (int i = 0; i < CMF_MBOX_N; i++) wr(ma(i, CMF_FLD_CTRL), 32'h0);
        wr(ga(CMF_GLB_MC), 32'h0);
        for (int i = 1; i < 4; i++) begin
            wr(ma(i, CMF_FLD_ID), i << 18);
            wr(ma(i, CMF_FLD_CTRL), i == 1 ? 32'h0000_0508 : 32'h0000_0908);
        end
        lo = $random(seed);
        hi = $random(seed);
        wr(ma(3, CMF_FLD_DLO), lo);
        wr(ma(3, CMF_FLD_DHI), hi);
        wr(ga(CMF_GLB_EN), 32'h0000_000E);
        wr(ga(CMF_GLB_TRS), 32'h0000_000E);
        repeat (2) @(posedge sys_clk);
        chk({tx_mbox, tx_dlc, tx_id}, {5'h03, 4'h8, 32'h000C_0000});
        chk(tx_data, {sw(hi), sw(lo)});
        wr(ma(3, CMF_FLD_DLO), ~lo);
        rd(ma(3, CMF_FLD_DLO), r);
        chk(r, lo);
        wr(ga(CMF_GLB_MC), 32'h0000_0103);
        repeat (2) @(posedge sys_clk);
        chk(tx_mbox, 2);
        wr(ma(3, CMF_FLD_DLO), ~lo);
        wr(ga(CMF_GLB_MC), 32'h0000_0400);
        data_byte_order = 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(tx_data, {hi, ~lo});
        hold <= 1'b0;
        wait (sent.size() == 3);
        chk({sent[0], sent[1], sent[2]}, {5'h03, 5'h02, 5'h01});
        hold <= 1'b1;
        $display("test transmit done");
        id = $random(seed);
        m = $random(seed) & 29'h1FFF_FFFE;
        wr(ma(5, CMF_FLD_ID), {3'b100, id ^ 29'h1});
        wr(ma(7, CMF_FLD_ID), {3'b110, id});
        wr(ma(8, CMF_FLD_ID), {3'b100, ~id});
        wr(ma(7, CMF_FLD_LAM), {3'b100, m});
        wr(ma(8, CMF_FLD_CTRL), 32'h0000_0010);
        wr(ga(CMF_GLB_DIR), 32'h0000_01A0);
        wr(ga(CMF_GLB_EN), 32'h0000_01AE);
        wr(ga(CMF_GLB_TRS), 32'h0000_0100);
        repeat (2) @(posedge sys_clk);
        chk({tx_mbox, tx_rtr}, {5'h08, 1'b1});
        hold <= 1'b0;
        wait (sent.size() == 4);
        repeat (4) @(posedge sys_clk);
        rd(ga(CMF_GLB_TRS), r);
        chk({sent[3], r[8]}, {5'h08, 1'b0});
        for (int i = 0; i < 16; i++) begin
            k = $random(seed);
            case (i == 0 ? 2'h0 : k[1:0])
                2'h0: x = id ^ 29'h1;
                2'h1: x = id ^ ($random(seed) & m);
                2'h2: x = id ^ 29'h1 ^ (29'h1 << (k[7:3] % 29));
                default: x = ~id;
            endcase
            frame(x, hit_of(x));
        end
        wr(ma(5, CMF_FLD_CTRL), 32'h0000_1F05);
        rd(ma(5, CMF_FLD_CTRL), r);
        chk(r, 32'h0000_0008);
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(ma(7, CMF_FLD_LAM), r);
        chk(r, {3'b100, m});
        $display("test enhanced filter done");
        wr(ga(CMF_GLB_MC), 32'h0000_3000);
        data_byte_order = 1'b0;
        x = $random(seed);
        wr(ma(10, CMF_FLD_ID), {3'b110, x ^ 29'h1});
        wr(ma(4, CMF_FLD_ID), {3'b110, x ^ 29'h2});
        wr(ma(3, CMF_FLD_LAM), 32'h0000_0002);
        wr(ga(CMF_GLB_DIR), 32'h0000_0410);
        wr(ga(CMF_GLB_EN), 32'h0000_0410);
        frame(x, 6'h24);
        wr(ga(CMF_GLB_GMASK), 32'h0000_0001);
        frame(x, 6'h2A);
        wr(ga(CMF_GLB_MC), 32'h0000_2000);
        wr(ga(CMF_GLB_GMASK), 32'h0);
        rd(ga(CMF_GLB_GMASK), r);
        chk(r, 32'h0000_0001);
        $display("test legacy filter done");
        stop_test();
    end
endmodule : tb_cmf_mailbox_filter
